// file: inc/ibs_pkg.sv
`default_nettype none

package ibs_pkg;

    // Register port geometry
    localparam int          ADDR_W           = 28;
    localparam int          DATA_W           = 8;

    // Register addresses
    localparam logic [27:0] BUS_STATUS_ADDR  = 28'hffffd86;
    localparam logic [27:0] SLAVE_ADDR_ADDR  = 28'hffffd8a;
    localparam logic [27:0] IRQ_STATUS_ADDR  = 28'hffffd8c;
    localparam logic [27:0] IRQ_ENABLE_ADDR  = 28'hffffd8d;
    localparam logic [27:0] IRQ_CLEAR_ADDR   = 28'hffffd8e;

    // Reset values
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  SLAVE_ADDR_RESET = 8'h00;
    localparam logic [3:0]  IRQ_RESET        = 4'h0;

    // Bus status field positions
    localparam int          MASTER_BIT       = 7;
    localparam int          ARB_LOST_BIT     = 6;
    localparam int          EXT_CODE_BIT     = 5;
    localparam int          ADDR_MATCH_BIT   = 4;

    // Interrupt event positions
    localparam int          EV_START         = 0;
    localparam int          EV_STOP          = 1;
    localparam int          EV_ARB_LOST      = 2;
    localparam int          EV_ADDR_BYTE     = 3;
    localparam int          EV_W             = 4;

    // Address byte decoding
    localparam logic [3:0]  EXT_CODE_LOW     = 4'h0;
    localparam logic [3:0]  EXT_CODE_HIGH    = 4'hf;
    localparam logic [3:0]  EIGHTH_CLOCK     = 4'h8;
    localparam logic [3:0]  BIT_COUNT_ZERO   = 4'h0;
    localparam logic [3:0]  BIT_COUNT_ONE    = 4'h1;

    // Register request from the processor side
    typedef struct packed {
        logic [27:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        bit_access;
        logic [2:0]  bit_sel;
    } ibs_req_t;

    // Flags handed in by the rest of the controller
    typedef struct packed {
        logic start_generated;
        logic comm_exit;
        logic unit_enable;
        logic sda_released;
        logic transmit_state;
        logic ack_seen;
    } ibs_ctl_t;

    // Bus phase
    typedef enum logic [1:0] {
        IBS_IDLE    = 2'b00,
        IBS_ADDRESS = 2'b01,
        IBS_DATA    = 2'b10
    } ibs_phase_t;

endpackage : ibs_pkg

`default_nettype wire

// file: rtl/ibs_status.sv
// How it works
// R1: Status register is read-only; byte reads and single-bit reads both supported.
// R2: Software reads status only while start trigger is set or during wait.
// R3: Reset clears status bits 7..4, 1 and 0, read data reads zero; transmit and ack follow the controller flags.
// R4: Bits 7..0: master, arb lost, ext code, match, transmit, ack, start, stop.
// R5: Master flag sets when this unit generates a start condition.
// R6: Master flag clears on stop, arb loss, exit, enable falling, reset.
// R7: Arbitration-lost flag sets when this unit loses bus arbitration.
// R8: Arbitration-lost flag clears after a status read, enable falling, reset.
// R9: A bit access to any other status bit also clears arbitration-lost.
// R10: Extension flag sets at eighth clock when address high nibble is 0000 or 1111.
// R11: Extension flag clears on start, stop, exit, enable falling, reset.
// R12: Match flag sets at eighth clock when address bits 7..1 equal slave address register bits 7..1.
// R13: Match flag clears on start, stop, exit, enable falling, reset.
// R14: Software never touches status while running from the subclock.
// R15: When set and clear of one flag coincide, clear wins; the interrupt status bits let a new event win over a clear write.
`timescale 1ns/1ps
`default_nettype none

module ibs_status (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Register port
    input  wire ibs_pkg::ibs_req_t req_in,
    output logic [7:0]            rdata_out,
    // Controller flags
    input  wire ibs_pkg::ibs_ctl_t ctl_in,
    // Bus pins, asynchronous
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    // Status outputs
    output logic                  master_active_out,
    output logic                  irq_out
);

    // Pin synchronisers
    logic [1:0] scl_sync_ff;
    logic [1:0] nxt_scl_sync;
    logic [1:0] sda_sync_ff;
    logic [1:0] nxt_sda_sync;
    logic       scl_prev_ff;
    logic       nxt_scl_prev;
    logic       sda_prev_ff;
    logic       nxt_sda_prev;

    // Bus tracking
    ibs_pkg::ibs_phase_t phase_ff;
    ibs_pkg::ibs_phase_t nxt_phase;
    logic [3:0]          bit_cnt_ff;
    logic [3:0]          nxt_bit_cnt;
    logic [7:0]          shift_ff;
    logic [7:0]          nxt_shift;
    logic                enable_prev_ff;
    logic                nxt_enable_prev;

    // Flags and registers
    logic       master_ff;
    logic       nxt_master;
    logic       arb_lost_ff;
    logic       nxt_arb_lost;
    logic       ext_code_ff;
    logic       nxt_ext_code;
    logic       match_ff;
    logic       nxt_match;
    logic       start_seen_ff;
    logic       nxt_start_seen;
    logic       stop_seen_ff;
    logic       nxt_stop_seen;
    logic [7:0] slave_addr_ff;
    logic [7:0] nxt_slave_addr;
    logic [3:0] irq_status_ff;
    logic [3:0] nxt_irq_status;
    logic [3:0] irq_enable_ff;
    logic [3:0] nxt_irq_enable;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       irq_ff;
    logic       nxt_irq;

    // Combinational helpers
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       start_det;
    logic       stop_det;
    logic       disable_evt;
    logic       common_clr;
    logic       eighth_clk;
    logic [7:0] rx_byte;
    logic       arb_loss_evt;
    logic       status_read;
    logic [7:0] status_word;
    logic [3:0] events;

    function automatic logic addr_hit(input logic [27:0] addr, input logic [27:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    function automatic logic is_ext_code(input logic [3:0] nibble);
        is_ext_code = (nibble == ibs_pkg::EXT_CODE_LOW) || (nibble == ibs_pkg::EXT_CODE_HIGH);
    endfunction : is_ext_code

    // Edges and conditions
    always_comb begin
        scl_s       = scl_sync_ff[1];
        sda_s       = sda_sync_ff[1];
        scl_rise    = scl_s && !scl_prev_ff;
        // Start and stop are SDA edges while SCL stays high
        start_det   = ctl_in.unit_enable && scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
        stop_det    = ctl_in.unit_enable && scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
        disable_evt = enable_prev_ff && !ctl_in.unit_enable;
        common_clr  = ctl_in.comm_exit || disable_evt;
        rx_byte     = {shift_ff[6:0], sda_s};
        eighth_clk  = scl_rise && (phase_ff == ibs_pkg::IBS_ADDRESS)
                      && (bit_cnt_ff == (ibs_pkg::EIGHTH_CLOCK - ibs_pkg::BIT_COUNT_ONE));
        // Lost when our released SDA is pulled low by another master
        arb_loss_evt = master_ff && scl_rise && ctl_in.sda_released && !sda_s;
        status_read = req_in.rd && addr_hit(req_in.addr, ibs_pkg::BUS_STATUS_ADDR);
        // R4 bit order
        status_word = {master_ff, arb_lost_ff, ext_code_ff, match_ff,
                       ctl_in.transmit_state, ctl_in.ack_seen, start_seen_ff, stop_seen_ff};
        events      = '0;
        events[ibs_pkg::EV_START]     = start_det;
        events[ibs_pkg::EV_STOP]      = stop_det;
        events[ibs_pkg::EV_ARB_LOST]  = arb_loss_evt;
        events[ibs_pkg::EV_ADDR_BYTE] = eighth_clk;
    end

    // Pin sampling and bus phase
    always_comb begin
        nxt_scl_sync    = {scl_sync_ff[0], scl_in};
        nxt_sda_sync    = {sda_sync_ff[0], sda_in};
        nxt_scl_prev    = scl_s;
        nxt_sda_prev    = sda_s;
        nxt_enable_prev = ctl_in.unit_enable;
        nxt_phase       = phase_ff;
        nxt_bit_cnt     = bit_cnt_ff;
        nxt_shift       = shift_ff;
        if (!ctl_in.unit_enable || stop_det || ctl_in.comm_exit) begin
            nxt_phase   = ibs_pkg::IBS_IDLE;
            nxt_bit_cnt = ibs_pkg::BIT_COUNT_ZERO;
        end else if (start_det) begin
            nxt_phase   = ibs_pkg::IBS_ADDRESS;
            nxt_bit_cnt = ibs_pkg::BIT_COUNT_ZERO;
        end else if (scl_rise) begin
            case (phase_ff)
                ibs_pkg::IBS_ADDRESS: begin
                    nxt_shift   = rx_byte;
                    nxt_bit_cnt = bit_cnt_ff + ibs_pkg::BIT_COUNT_ONE;
                    if (eighth_clk) begin
                        nxt_phase = ibs_pkg::IBS_DATA;
                    end
                end
                default: begin
                    nxt_bit_cnt = bit_cnt_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            scl_sync_ff    <= 2'h3;
            sda_sync_ff    <= 2'h3;
            scl_prev_ff    <= 1'h1;
            sda_prev_ff    <= 1'h1;
            enable_prev_ff <= 1'h0;
            phase_ff       <= ibs_pkg::IBS_IDLE;
            bit_cnt_ff     <= ibs_pkg::BIT_COUNT_ZERO;
            shift_ff       <= ibs_pkg::SLAVE_ADDR_RESET;
        end else begin
            scl_sync_ff    <= nxt_scl_sync;
            sda_sync_ff    <= nxt_sda_sync;
            scl_prev_ff    <= nxt_scl_prev;
            sda_prev_ff    <= nxt_sda_prev;
            enable_prev_ff <= nxt_enable_prev;
            phase_ff       <= nxt_phase;
            bit_cnt_ff     <= nxt_bit_cnt;
            shift_ff       <= nxt_shift;
        end
    end

    // Status flags; every clear term is tested before its set term
    always_comb begin
        nxt_master     = master_ff;
        nxt_arb_lost   = arb_lost_ff;
        nxt_ext_code   = ext_code_ff;
        nxt_match      = match_ff;
        nxt_start_seen = start_seen_ff;
        nxt_stop_seen  = stop_seen_ff;
        // R6 master clear, R15 clear wins
        if (stop_det || arb_lost_ff || arb_loss_evt || common_clr) begin
            nxt_master = 1'h0;
        // R5 master set
        end else if (ctl_in.start_generated) begin
            nxt_master = 1'h1;
        end
        // R8 R9 any status byte or bit read clears
        if (status_read || disable_evt) begin
            nxt_arb_lost = 1'h0;
        // R7 arbitration loss
        end else if (arb_loss_evt) begin
            nxt_arb_lost = 1'h1;
        end
        // R11 R13 extension and match clear
        if (start_det || stop_det || common_clr) begin
            nxt_ext_code = 1'h0;
            nxt_match    = 1'h0;
        end else if (eighth_clk) begin
            // R10 extension code detect
            nxt_ext_code = is_ext_code(rx_byte[7:4]);
            // R12 own address compare
            nxt_match    = (rx_byte[7:1] == slave_addr_ff[7:1]);
        end
        if (stop_det || common_clr) begin
            nxt_start_seen = 1'h0;
        end else if (start_det) begin
            nxt_start_seen = 1'h1;
        end
        if (start_det || common_clr) begin
            nxt_stop_seen = 1'h0;
        end else if (stop_det) begin
            nxt_stop_seen = 1'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        // R3 reset to zero
        if (reset_in) begin
            master_ff     <= ibs_pkg::STATUS_RESET[ibs_pkg::MASTER_BIT];
            arb_lost_ff   <= ibs_pkg::STATUS_RESET[ibs_pkg::ARB_LOST_BIT];
            ext_code_ff   <= ibs_pkg::STATUS_RESET[ibs_pkg::EXT_CODE_BIT];
            match_ff      <= ibs_pkg::STATUS_RESET[ibs_pkg::ADDR_MATCH_BIT];
            start_seen_ff <= 1'h0;
            stop_seen_ff  <= 1'h0;
        end else begin
            master_ff     <= nxt_master;
            arb_lost_ff   <= nxt_arb_lost;
            ext_code_ff   <= nxt_ext_code;
            match_ff      <= nxt_match;
            start_seen_ff <= nxt_start_seen;
            stop_seen_ff  <= nxt_stop_seen;
        end
    end

    // Register port, interrupt block and read data
    always_comb begin
        nxt_slave_addr = slave_addr_ff;
        nxt_irq_enable = irq_enable_ff;
        nxt_irq_status = irq_status_ff;
        nxt_rdata      = 8'h00;
        // Writes to the status address fall through: the register is read-only
        if (req_in.wr && addr_hit(req_in.addr, ibs_pkg::SLAVE_ADDR_ADDR)) begin
            nxt_slave_addr = req_in.wdata;
        end else if (req_in.wr && addr_hit(req_in.addr, ibs_pkg::IRQ_ENABLE_ADDR)) begin
            nxt_irq_enable = req_in.wdata[3:0];
        end else if (req_in.wr && addr_hit(req_in.addr, ibs_pkg::IRQ_CLEAR_ADDR)) begin
            nxt_irq_status = irq_status_ff & ~req_in.wdata[3:0];
        end
        // A new event outranks a clear written in the same cycle
        nxt_irq_status = nxt_irq_status | events;
        // R1 byte or single bit read
        if (status_read && req_in.bit_access) begin
            nxt_rdata = {7'h00, status_word[req_in.bit_sel]};
        end else if (status_read) begin
            nxt_rdata = status_word;
        end else if (req_in.rd && addr_hit(req_in.addr, ibs_pkg::SLAVE_ADDR_ADDR)) begin
            nxt_rdata = slave_addr_ff;
        end else if (req_in.rd && addr_hit(req_in.addr, ibs_pkg::IRQ_STATUS_ADDR)) begin
            nxt_rdata = {4'h0, irq_status_ff};
        end else if (req_in.rd && addr_hit(req_in.addr, ibs_pkg::IRQ_ENABLE_ADDR)) begin
            nxt_rdata = {4'h0, irq_enable_ff};
        end
        nxt_irq = |(nxt_irq_status & nxt_irq_enable);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            slave_addr_ff <= ibs_pkg::SLAVE_ADDR_RESET;
            irq_enable_ff <= ibs_pkg::IRQ_RESET;
            irq_status_ff <= ibs_pkg::IRQ_RESET;
            rdata_ff      <= ibs_pkg::STATUS_RESET;
            irq_ff        <= 1'h0;
        end else begin
            slave_addr_ff <= nxt_slave_addr;
            irq_enable_ff <= nxt_irq_enable;
            irq_status_ff <= nxt_irq_status;
            rdata_ff      <= nxt_rdata;
            irq_ff        <= nxt_irq;
        end
    end

    assign rdata_out         = rdata_ff;
    assign irq_out           = irq_ff;
    assign master_active_out = master_ff;

endmodule : ibs_status

`default_nettype wire

// file: test/ibs_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module ibs_status_chk (
    // Clock and reset
    input wire logic              clk_in,
    input wire logic              reset_in,
    // Register port
    input wire ibs_pkg::ibs_req_t req_in,
    input wire logic [7:0]        rdata_out,
    // Controller and bus
    input wire ibs_pkg::ibs_ctl_t ctl_in,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              master_active_out,
    input wire logic              irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_stop;
        scl_in && $rose(sda_in) && ctl_in.unit_enable;
    endsequence
    sequence s_status_rd;
        req_in.rd && req_in.addr == ibs_pkg::BUS_STATUS_ADDR;
    endsequence

    a_reset_clears_all:
        assert property (disable iff (1'b0) reset_in |=> !master_active_out && !irq_out
            && rdata_out == 8'h00) else $error("outputs not cleared by reset");
    a_master_set_cause:
        assert property ($rose(master_active_out) |-> $past(ctl_in.start_generated))
        else $error("master flag rose without a start");
    a_exit_clears_master:
        assert property (ctl_in.comm_exit |=> !master_active_out)
        else $error("master flag survived exit");
    a_enable_fall_clears:
        assert property ($fell(ctl_in.unit_enable) |=> !master_active_out)
        else $error("master flag survived enable fall");
    a_stop_clears_master:
        assert property (s_stop |-> ##[1:6] !master_active_out)
        else $error("master flag survived stop");
    a_rdata_idle_zero:
        assert property (!req_in.rd |=> rdata_out == 8'h00)
        else $error("read data without a read");
    a_bit_read_upper:
        assert property (s_status_rd and req_in.bit_access |=> rdata_out[7:1] == 7'h00)
        else $error("bit read upper bits not zero");
    a_byte_master_pos:
        assert property (s_status_rd and !req_in.bit_access
            |=> rdata_out[7] == $past(master_active_out))
        else $error("master flag not in bit 7");
    a_irq_mask_off:
        assert property (req_in.wr && req_in.addr == ibs_pkg::IRQ_ENABLE_ADDR
            && req_in.wdata[3:0] == 4'h0 |=> ##[0:1] !irq_out)
        else $error("interrupt high while all masked");
endmodule : ibs_status_chk

bind ibs_status ibs_status_chk u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .req_in(req_in), .rdata_out(rdata_out),
    .ctl_in(ctl_in), .scl_in(scl_in), .sda_in(sda_in),
    .master_active_out(master_active_out), .irq_out(irq_out));

`default_nettype wire

// file: test/ibs_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none

module ibs_bus_peer (
    // Bus lines, pulled up when released
    output var logic scl_out,
    output var logic sda_out
);
    // Clock stands high outside frames
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Offset keeps pin edges away from the sampling edge
    task automatic start_cond();
        #3 sda_out = 1'b0;
        #100 scl_out = 1'b0;
        #100;
    endtask : start_cond
    // MSB first, 200 ns clock period
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_out = b[i];
            #50 scl_out = 1'b1;
            #100 scl_out = 1'b0;
            #50;
        end
    endtask : send_byte
    task automatic stop_cond();
        sda_out = 1'b0;
        #100 scl_out = 1'b1;
        #100 sda_out = 1'b1;
        #200;
    endtask : stop_cond
endmodule : ibs_bus_peer

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic              clk_in = 1'b0;
    logic              reset_in = 1'b1;
    ibs_pkg::ibs_req_t req = '0;
    ibs_pkg::ibs_ctl_t ctl = '0;
    wire logic         scl;
    wire logic         sda;
    logic [7:0]        rdata;
    logic              master;
    logic              irq;
    int                error_cnt = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    logic [7:0]        seen;
    logic [7:0]        slv;
    logic [7:0]        exp;
    logic [7:0]        q[$];
    localparam logic [27:0] ST = ibs_pkg::BUS_STATUS_ADDR;

    always #12.5 clk_in = ~clk_in;

    ibs_status DUT (.clk_in(clk_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata),
        .ctl_in(ctl), .scl_in(scl), .sda_in(sda), .master_active_out(master), .irq_out(irq));
    ibs_bus_peer peer (.scl_out(scl), .sda_out(sda));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, e, s);
        end
    endtask : chk

    task automatic wr(input logic [27:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0, bit_access:1'b0, bit_sel:3'h0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    // reads stand for software inside its legal window
    task automatic rd(input logic [27:0] a, input logic bt, input logic [2:0] s,
                      output logic [7:0] v);
        @(posedge clk_in);
        req <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1, bit_access:bt, bit_sel:s};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic pulse(input logic st, input logic ex);
        @(posedge clk_in);
        ctl.start_generated <= st;
        ctl.comm_exit <= ex;
        @(posedge clk_in);
        ctl.start_generated <= 1'b0;
        ctl.comm_exit <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : pulse

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_in);
        #1 chk("irq_out", {7'h00, irq}, {7'h00, e});
    endtask : irq_is

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'h393cc8d6));
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(ST, 1'b0, 3'h0, seen); chk("status reset", seen, 8'h00);
        wr(ST, 8'hff);
        rd(ST, 1'b0, 3'h0, seen); chk("status write", seen, 8'h00);
        rd(28'h0000000, 1'b0, 3'h0, seen); chk("unmapped", seen, 8'h00);
        $display("done: reset and access");
        slv = 8'($urandom()) & 8'hfe;
        @(posedge clk_in);
        ctl.unit_enable <= 1'b1;
        wr(ibs_pkg::SLAVE_ADDR_ADDR, slv);
        q = '{slv, 8'h05, 8'hf3, 8'($urandom())};
        foreach (q[i]) begin
            peer.start_cond();
            peer.send_byte(q[i]);
            repeat (8) @(posedge clk_in);
            exp = 8'h02;
            exp[5] = (q[i][7:4] == 4'h0 || q[i][7:4] == 4'hf);
            exp[4] = (q[i][7:1] == slv[7:1]);
            rd(ST, 1'b0, 3'h0, seen); chk("status address", seen, exp);
            peer.stop_cond();
            repeat (8) @(posedge clk_in);
            rd(ST, 1'b0, 3'h0, seen); chk("status stop", seen, 8'h01);
        end
        $display("done: address bytes");
        rd(ibs_pkg::IRQ_STATUS_ADDR, 1'b0, 3'h0, seen); chk("irq status", seen, 8'h0b);
        wr(ibs_pkg::IRQ_ENABLE_ADDR, 8'h0f); irq_is(1'b1);
        wr(ibs_pkg::IRQ_ENABLE_ADDR, 8'h00); irq_is(1'b0);
        wr(ibs_pkg::IRQ_ENABLE_ADDR, 8'h0f);
        wr(ibs_pkg::IRQ_CLEAR_ADDR, 8'h0f); irq_is(1'b0);
        rd(ibs_pkg::IRQ_STATUS_ADDR, 1'b0, 3'h0, seen); chk("irq cleared", seen, 8'h00);
        $display("done: interrupts");
        pulse(1'b1, 1'b0);
        rd(ST, 1'b1, 3'h7, seen); chk("master set", seen, 8'h01);
        chk("master_active_out", {7'h00, master}, 8'h01);
        pulse(1'b0, 1'b1);
        rd(ST, 1'b1, 3'h7, seen); chk("master exit", seen, 8'h00);
        pulse(1'b1, 1'b1);
        rd(ST, 1'b1, 3'h7, seen); chk("master clash", seen, 8'h00);
        pulse(1'b1, 1'b0);
        ctl.unit_enable <= 1'b0;
        pulse(1'b0, 1'b0);
        ctl.unit_enable <= 1'b1;
        rd(ST, 1'b1, 3'h7, seen); chk("master enable", seen, 8'h00);
        chk("master_active_out", {7'h00, master}, 8'h00);
        @(posedge clk_in);
        ctl.transmit_state <= 1'b1;
        rd(ST, 1'b0, 3'h0, seen); chk("transmit bit", seen, 8'h08);
        @(posedge clk_in);
        ctl.transmit_state <= 1'b0;
        ctl.ack_seen <= 1'b1;
        rd(ST, 1'b1, 3'h2, seen); chk("ack bit", seen, 8'h01);
        @(posedge clk_in);
        ctl.ack_seen <= 1'b0;
        // Start then stop on an idle bus while this unit is master
        pulse(1'b1, 1'b0);
        rd(ST, 1'b1, 3'h7, seen); chk("master before stop", seen, 8'h01);
        peer.stop_cond();
        rd(ST, 1'b1, 3'h7, seen); chk("master stop", seen, 8'h00);
        chk("master_active_out", {7'h00, master}, 8'h00);
        $display("done: master flag");
        @(posedge clk_in);
        ctl.sda_released <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            pulse(1'b1, 1'b0);
            peer.start_cond();
            peer.send_byte(8'h00);
            repeat (8) @(posedge clk_in);
            if (k == 1)
                rd(ST, 1'b1, 3'h3, seen);
            else begin
                rd(ST, 1'b0, 3'h0, seen); chk("arb lost", seen & 8'hc0, 8'h40);
            end
            rd(ST, 1'b0, 3'h0, seen); chk("arb cleared", seen & 8'h40, 8'h00);
            peer.stop_cond();
        end
        $display("done: arbitration");
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
